// File: eci_pkg.sv
// package of constants and types for the external control i/o block
package eci_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 25_000_000;
    localparam int unsigned TRIG_IN_MIN_NS   = 10_000;
    localparam int unsigned TRIGGER_OUTPUT_MIN_NS  = 2_000;
    // least times round up to whole cycles
    localparam int unsigned TRIG_IN_CYC  = (TRIG_IN_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned TRIGGER_OUTPUT_CYC = (TRIGGER_OUTPUT_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CNT_W        = 9;

    // ------------------------------------------------------------
    // register map (32-bit words, byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_ST = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MK = 4'hC;

    // control field positions
    localparam int unsigned CTRL_MAN_RANGE_LSB = 0;  // 2 bits
    localparam int unsigned CTRL_EXT_MODE_LSB  = 2;  // 2 bits
    localparam int unsigned CTRL_SEQ_PAUSE     = 4;  // write 1: pause sequence
    localparam int unsigned CTRL_SHORT         = 5;
    localparam int unsigned CTRL_DYN_SWITCH    = 6;  // write 1: pulse event
    localparam int unsigned CTRL_STEP_EXEC     = 7;  // write 1: pulse event
    localparam int unsigned CTRL_STEP_TRIG_EN  = 8;
    localparam logic [8:0]  CTRL_RESET         = 9'h000;

    // irq status / mask bit positions
    localparam int unsigned IRQ_ALARM  = 0;
    localparam int unsigned IRQ_RESUME = 1;
    localparam int unsigned IRQ_TRIG   = 2;
    localparam int unsigned IRQ_W      = 3;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RANGE_HIGH = 2'h0,
        RANGE_MID  = 2'h1,
        RANGE_LOW  = 2'h2
    } eci_range_t;

    // external control setting: off or one of three enabling values
    typedef enum logic [1:0] {
        EXT_OFF  = 2'h0,
        EXT_V    = 2'h1,
        EXT_R    = 2'h2,
        EXT_RIV  = 2'h3
    } eci_ext_mode_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic range_sel_1;   // upper select pin
        logic range_sel_0;   // lower select pin
        logic trig_in;       // active high
        logic alarm_n;       // active low
    } eci_pins_in_t;

    typedef struct packed {
        logic range_stat_1;
        logic range_stat_0;
        logic short_relay;
        logic trigger_output;
    } eci_pins_out_t;

endpackage : eci_pkg

// File: eci_top.sv
// external control i/o: range select, range status, trigger, alarm, short relay
//
// Functional notes
// R1: sel pins HH selects high, HL middle, LH low range.
// R2: pin range selection honoured only while manual range is high.
// R3: pin range selection needs external control setting V, R or Riv.
// R4: status outputs off,off high; second on middle; first on low.
// R5: valid trigger input pulse resumes a paused sequence.
// R6: trigger input must stay high 10us; shorter pulses ignored.
// R7: alarm input low means alarm active; high or open means inactive.
// R8: active external alarm also raises the external alarm message.
// R9: alarm from any instrument or parallel slave handled alike.
// R10: short relay contact open, closed only while short function active.
// R11: trigger output on dynamic switching and enabled sequence step execution.
// R12: trigger output pulse is active high and at least 2us.
// R13: all pin inputs pass two flip-flops before any logic reads them.
`timescale 1ns/1ps

module eci_top
    import eci_pkg::*;
(
    // clock and reset
    input  wire logic          clock_i,
    input  wire logic          nrst_i,
    // avalon-mm slave
    input  wire logic [3:0]    avs_address_i,
    input  wire logic          avs_read_i,
    input  wire logic          avs_write_i,
    input  wire logic [31:0]   avs_writedata_i,
    input  wire logic [3:0]    avs_byteenable_i,
    output logic [31:0]        avs_readdata_o,
    output logic               avs_waitrequest_o,
    // connector pins
    input  wire eci_pins_in_t  pins_i,
    output eci_pins_out_t      pins_o,
    // internal state towards the rest of the load
    output eci_range_t         active_range_o,
    output logic               seq_paused_o,
    output logic               alarm_active_o,
    output logic               external_alarm_message_o,
    // interrupt
    output logic               irq_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    eci_pins_in_t sync_a;
    eci_pins_in_t sync_b;

    // two stages, only sync_b is read by logic [R13]
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            // idle levels: pulled-up selects and alarm, pulled-down trigger,
            // so no false trigger level is seen right after reset
            sync_a <= 4'hD;
            sync_b <= 4'hD;
        end else begin
            sync_a <= pins_i;
            sync_b <= sync_a;    // [R13]
        end
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic [8:0]        ctrl;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  irq_events;
    logic              bus_ack;
    logic              wr_ctrl;
    logic              wr_irq_st;
    logic              wr_irq_mk;
    logic              pause_req;
    logic              dyn_pulse;
    logic              step_pulse;

    // one wait cycle: request taken at the edge where waitrequest is low
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read_i || avs_write_i) && !bus_ack;
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !bus_ack;

    assign wr_ctrl   = avs_write_i && bus_ack && avs_address_i == ADDR_CTRL && avs_byteenable_i[0];
    assign wr_irq_st = avs_write_i && bus_ack && avs_address_i == ADDR_IRQ_ST && avs_byteenable_i[0];
    assign wr_irq_mk = avs_write_i && bus_ack && avs_address_i == ADDR_IRQ_MK && avs_byteenable_i[0];

    // control register; command bits are self clearing and not stored
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= avs_writedata_i[8:0];
            ctrl[CTRL_SEQ_PAUSE]  <= 1'b0;
            ctrl[CTRL_DYN_SWITCH] <= 1'b0;
            ctrl[CTRL_STEP_EXEC]  <= 1'b0;
            if (avs_byteenable_i[1] == 1'b0) begin
                ctrl[8] <= ctrl[8];
            end
        end
    end

    assign pause_req  = wr_ctrl && avs_writedata_i[CTRL_SEQ_PAUSE];
    assign dyn_pulse  = wr_ctrl && avs_writedata_i[CTRL_DYN_SWITCH];
    assign step_pulse = wr_ctrl && avs_writedata_i[CTRL_STEP_EXEC];

    // read data is registered; unmapped addresses read zero
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !bus_ack) begin
            unique case (avs_address_i)
                ADDR_CTRL:   avs_readdata_o <= {23'h000000, ctrl};
                ADDR_STATUS: avs_readdata_o <= {24'h000000, sync_b, seq_paused_o, alarm_active_o,
                                                active_range_o};
                ADDR_IRQ_ST: avs_readdata_o <= {29'h00000000, irq_status};
                ADDR_IRQ_MK: avs_readdata_o <= {29'h00000000, irq_mask};
                default:     avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // range selection and status
    // ------------------------------------------------------------
    eci_range_t    man_range;
    eci_ext_mode_t ext_mode;
    eci_range_t    next_range;

    assign man_range = eci_range_t'(ctrl[CTRL_MAN_RANGE_LSB +: 2]);
    assign ext_mode  = eci_ext_mode_t'(ctrl[CTRL_EXT_MODE_LSB +: 2]);

    // decode of the two select pins [R1]
    function automatic eci_range_t pin_range(input logic hi, input logic lo);
        if (hi && lo) begin
            pin_range = RANGE_HIGH;
        end else if (hi) begin
            pin_range = RANGE_MID;
        end else if (lo) begin
            pin_range = RANGE_LOW;
        end else begin
            pin_range = RANGE_HIGH;   // both low is undefined; keep the widest range
        end
    endfunction

    always_comb begin
        next_range = man_range;
        // pins only act with external control on and manual range high [R2] [R3]
        if (ext_mode != EXT_OFF && man_range == RANGE_HIGH) begin
            next_range = pin_range(sync_b.range_sel_1, sync_b.range_sel_0); // [R1]
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            active_range_o <= RANGE_HIGH;
        end else begin
            active_range_o <= next_range;
        end
    end

    // status pins: first on for low, second on for middle [R4]
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            pins_o.range_stat_1 <= 1'b0;
            pins_o.range_stat_0 <= 1'b0;
        end else begin
            pins_o.range_stat_1 <= (next_range == RANGE_LOW);  // [R4]
            pins_o.range_stat_0 <= (next_range == RANGE_MID);  // [R4]
        end
    end

    // ------------------------------------------------------------
    // trigger input: width qualification and sequence resume
    // ------------------------------------------------------------
    logic [CNT_W-1:0] trig_in_cnt;
    logic             trig_valid;

    // pulse counts only once it has been high the full minimum width [R6]
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            trig_in_cnt <= '0;
        end else if (!sync_b.trig_in) begin
            trig_in_cnt <= '0;
        end else if (trig_in_cnt != CNT_W'(TRIG_IN_CYC)) begin
            trig_in_cnt <= trig_in_cnt + 1'b1;
        end
    end

    // one pulse per qualified high level, at the cycle the width is reached
    assign trig_valid = sync_b.trig_in && trig_in_cnt == CNT_W'(TRIG_IN_CYC - 1); // [R6]

    // pause set by software, cleared by a valid trigger; resume wins [R5]
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            seq_paused_o <= 1'b0;
        end else if (trig_valid && seq_paused_o) begin
            seq_paused_o <= 1'b0;    // [R5]
        end else if (pause_req) begin
            seq_paused_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // external alarm
    // ------------------------------------------------------------
    logic alarm_q;

    // low level is active, any source alike [R7] [R9]
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            alarm_active_o           <= 1'b0;
            external_alarm_message_o <= 1'b0;
            alarm_q                  <= 1'b0;
        end else begin
            alarm_active_o           <= !sync_b.alarm_n;  // [R7] [R9]
            external_alarm_message_o <= !sync_b.alarm_n;  // [R8]
            alarm_q                  <= alarm_active_o;
        end
    end

    // ------------------------------------------------------------
    // short relay and trigger output
    // ------------------------------------------------------------
    logic [CNT_W-1:0] trigger_output_cnt;
    logic             trig_fire;

    // relay closed only while the short function is on [R10]
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            pins_o.short_relay <= 1'b0;
        end else begin
            pins_o.short_relay <= ctrl[CTRL_SHORT]; // [R10]
        end
    end

    assign trig_fire = dyn_pulse || (step_pulse && avs_writedata_i[CTRL_STEP_TRIG_EN]); // [R11]

    // a new event restarts the width, so back to back events merge
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            trigger_output_cnt <= '0;
        end else if (trig_fire) begin
            trigger_output_cnt <= CNT_W'(TRIGGER_OUTPUT_CYC);  // [R12]
        end else if (trigger_output_cnt != '0) begin
            trigger_output_cnt <= trigger_output_cnt - 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            pins_o.trigger_output <= 1'b0;
        end else begin
            pins_o.trigger_output <= trig_fire || trigger_output_cnt > CNT_W'(1); // [R12]
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign irq_events[IRQ_ALARM]  = alarm_active_o && !alarm_q;
    assign irq_events[IRQ_RESUME] = trig_valid && seq_paused_o;
    assign irq_events[IRQ_TRIG]   = trig_fire;

    // an event in the clearing cycle wins over the clear
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~(wr_irq_st ? avs_writedata_i[IRQ_W-1:0] : '0)) | irq_events;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            irq_mask <= '0;
        end else if (wr_irq_mk) begin
            irq_mask <= avs_writedata_i[IRQ_W-1:0];
        end
    end

    assign irq_o = |(irq_status & irq_mask);

endmodule // eci_top

// File: eci_top_checker.sv
// concurrent checks on the ports of the external control i/o block
`timescale 1ns/1ps
module eci_top_checker
    import eci_pkg::*;
(
    // clock and reset
    input wire logic          clock_i,
    input wire logic          nrst_i,
    // bus
    input wire logic [3:0]    avs_address_i,
    input wire logic          avs_write_i,
    input wire logic [31:0]   avs_writedata_i,
    input wire logic [3:0]    avs_byteenable_i,
    input wire logic          avs_waitrequest_o,
    // pins and state
    input wire eci_pins_in_t  pins_i,
    input wire eci_pins_out_t pins_o,
    input wire eci_range_t    active_range_o,
    input wire logic          seq_paused_o,
    input wire logic          alarm_active_o,
    input wire logic          external_alarm_message_o
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic       wr_ok;
    logic [8:0] out_hi;
    logic [8:0] trig_run;
    logic [8:0] trig_last;
    assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_address_i == ADDR_CTRL && avs_byteenable_i[0];
    // run lengths saturate so a long level cannot wrap back under the limit
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            out_hi    <= '0;
            trig_run  <= '0;
            trig_last <= '0;
        end else begin
            out_hi   <= pins_o.trigger_output ? out_hi + (out_hi != 9'h1FF) : 9'h000;
            trig_run <= pins_i.trig_in ? trig_run + (trig_run != 9'h1FF) : 9'h000;
            if (!pins_i.trig_in && trig_run != 0) trig_last <= trig_run;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_range_status_map: assert property (pins_o.range_stat_0 == (active_range_o == RANGE_MID) &&
        pins_o.range_stat_1 == (active_range_o == RANGE_LOW)) else $error("range status pins wrong");
    a_alarm_follow: assert property (!pins_i.alarm_n [*4] |-> alarm_active_o)
        else $error("alarm not active after low input");
    a_alarm_latency: assert property ($rose(alarm_active_o) |-> !$past(pins_i.alarm_n, 3))
        else $error("alarm rose without synchronised low");
    a_alarm_message: assert property (external_alarm_message_o == alarm_active_o)
        else $error("alarm message differs from alarm");
    a_trig_width: assert property ($fell(pins_o.trigger_output) |-> out_hi >= TRIGGER_OUTPUT_CYC)
        else $error("trigger output pulse too short");
    a_trig_cause: assert property ($rose(pins_o.trigger_output) |->
        $past(wr_ok && (avs_writedata_i[CTRL_DYN_SWITCH] ||
        avs_writedata_i[CTRL_STEP_EXEC] && avs_writedata_i[CTRL_STEP_TRIG_EN])))
        else $error("trigger output without event");
    a_dyn_trig: assert property (wr_ok && avs_writedata_i[6] |=> pins_o.trigger_output)
        else $error("dynamic switch gave no trigger output");
    a_short_close: assert property (wr_ok && avs_writedata_i[5] |-> ##[1:2] pins_o.short_relay)
        else $error("short relay did not close");
    a_resume_len: assert property ($fell(seq_paused_o) |-> trig_run >= TRIG_IN_CYC ||
        trig_last >= TRIG_IN_CYC) else $error("resume without long trigger");
    c_dyn: cover property (wr_ok && avs_writedata_i[6]);
    c_resume: cover property ($fell(seq_paused_o));
    c_alarm: cover property ($rose(alarm_active_o));
endmodule // eci_top_checker
bind eci_top eci_top_checker eci_top_checker_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .avs_address_i(avs_address_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o), .pins_i(pins_i),
    .pins_o(pins_o), .active_range_o(active_range_o), .seq_paused_o(seq_paused_o),
    .alarm_active_o(alarm_active_o), .external_alarm_message_o(external_alarm_message_o));

// File: eci_ext_model.sv
// far side of the connector: switches, trigger source, alarm sources
`timescale 1ns/1ps
module eci_ext_model
    import eci_pkg::*;
(
    // clock and reset
    input  wire logic     clock_i,
    input  wire logic     nrst_i,
    // commands
    input  wire logic [1:0] sel_i,
    input  wire logic     inst_alarm_n_i,
    input  wire logic     slave_alarm_n_i,
    input  wire logic     trig_go_i,
    input  wire logic [8:0] trig_len_i,
    // pins
    output eci_pins_in_t  pins_o
);
    logic [8:0] trig_cnt;
    // trigger source holds the line high for the commanded count of cycles
    always_ff @(posedge clock_i) begin
        if (!nrst_i) trig_cnt <= '0;
        else if (trig_go_i) trig_cnt <= trig_len_i;
        else if (trig_cnt != 0) trig_cnt <= trig_cnt - 9'h001;
    end
    // open-collector alarm sources share one pulled-up line
    assign pins_o = eci_pins_in_t'({sel_i, trig_cnt != 0, inst_alarm_n_i & slave_alarm_n_i});
endmodule // eci_ext_model

// File: testbench.sv
// self-checking bench for the external control i/o block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
    import eci_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o, seq_paused_o, irq_o;
    logic alarm_active_o, external_alarm_message_o, inst_n, slave_n, trig_go;
    logic [3:0] avs_address_i, avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [1:0] sel;
    logic [8:0] trig_len;
    eci_pins_in_t pins_i;
    eci_pins_out_t pins_o;
    eci_range_t active_range_o;
    int err_count, n_checks, cyc, cnt;
    // rows: ext mode, manual range, select pins, expected range; both selects low keeps high
    logic [7:0] rows [9] = '{8'h4C, 8'h49, 8'h86, 8'hC9, 8'h04, 8'h55, 8'h6A, 8'h8C, 8'h40};
    logic [8:0] trg [3] = '{9'h040, 9'h180, 9'h080};
    eci_top eci_top_i (.clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .pins_i(pins_i), .pins_o(pins_o),
        .active_range_o(active_range_o), .seq_paused_o(seq_paused_o), .alarm_active_o(alarm_active_o),
        .external_alarm_message_o(external_alarm_message_o), .irq_o(irq_o));
    eci_ext_model eci_ext_model_i (.clock_i(clock_i), .nrst_i(nrst_i), .sel_i(sel), .inst_alarm_n_i(inst_n),
        .slave_alarm_n_i(slave_n), .trig_go_i(trig_go), .trig_len_i(trig_len), .pins_o(pins_i));
    // ------------------------------------------------------------
    // clock, timeout, tasks
    // ------------------------------------------------------------
    initial begin
        clock_i = 0;
        forever #20 clock_i = ~clock_i;
    end
    // a hang counts as a mismatch and closes the run
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            print_verdict();
        end
    end
    task print_verdict;
        if (err_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one bus access; the extra edge keeps the next request out of this time step
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 0;
        avs_read_i <= 0;
        @(posedge clock_i);
    endtask
    task automatic pulse(input int n);
        trig_len <= n[8:0];
        trig_go <= 1;
        @(posedge clock_i);
        trig_go <= 0;
        repeat (n + 10) @(posedge clock_i);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {avs_read_i, avs_write_i, trig_go, avs_address_i, avs_writedata_i, sel} = '0;
        {inst_n, slave_n, avs_byteenable_i, trig_len, nrst_i} = {2'h3, 4'hF, 10'h000};
        repeat (5) @(posedge clock_i);
        nrst_i <= 1;
        `CHK(active_range_o, RANGE_HIGH)
        `CHK(pins_o, 4'h0)
        bus(0, 4'h2, 32'h0);
        `CHK(q, 32'h0)
        foreach (rows[i]) begin
            sel <= rows[i][3:2];
            bus(1, ADDR_CTRL, {28'h0, rows[i][7:4]});
            repeat (6) @(posedge clock_i);
            `CHK(active_range_o, eci_range_t'(rows[i][1:0]))
            `CHK({pins_o.range_stat_1, pins_o.range_stat_0}, {rows[i][1:0] == 2'h2, rows[i][1:0] == 2'h1})
        end
        for (int i = 1; i >= 0; i--) begin
            bus(1, ADDR_CTRL, 32'h20 * i);
            // the relay follows one edge after the accepted write
            @(posedge clock_i);
            `CHK(pins_o.short_relay, i[0])
        end
        // the bus task's trailing edge may hide up to two high cycles
        foreach (trg[i]) begin
            bus(1, ADDR_CTRL, {23'h0, trg[i]});
            cnt = 0;
            repeat (80) @(posedge clock_i) cnt += (pins_o.trigger_output === 1'b1);
            `CHK(cnt >= TRIGGER_OUTPUT_CYC - 2, i != 2)
        end
        bus(1, ADDR_IRQ_MK, 32'h2);
        bus(1, ADDR_CTRL, 32'h10);
        `CHK(seq_paused_o, 1'b1)
        pulse(TRIG_IN_CYC - 1);
        `CHK(seq_paused_o, 1'b1)
        pulse(TRIG_IN_CYC + 5);
        `CHK(seq_paused_o, 1'b0)
        `CHK(irq_o, 1'b1)
        bus(1, ADDR_IRQ_ST, 32'h2);
        `CHK(irq_o, 1'b0)
        bus(1, ADDR_IRQ_MK, 32'h1);
        for (int i = 0; i < 2; i++) begin
            inst_n <= i[0];
            slave_n <= !i[0];
            repeat (5) @(posedge clock_i);
            `CHK(alarm_active_o, 1'b1)
            `CHK(external_alarm_message_o, 1'b1)
            `CHK(irq_o, 1'b1)
            bus(0, ADDR_STATUS, 32'h0);
            `CHK(q[2], 1'b1)
            {inst_n, slave_n} <= 2'h3;
            bus(1, ADDR_IRQ_ST, 32'h1);
            repeat (5) @(posedge clock_i);
            `CHK(alarm_active_o, 1'b0)
            `CHK(irq_o, 1'b0)
        end
        // a reset in mid-run opens the relay and drops the range back to high
        bus(1, ADDR_CTRL, 32'h0000_0026);
        @(posedge clock_i);
        `CHK(pins_o.short_relay, 1'b1)
        `CHK(active_range_o, RANGE_LOW)
        nrst_i <= 0;
        repeat (3) @(posedge clock_i);
        `CHK(pins_o, 4'h0)
        `CHK(active_range_o, RANGE_HIGH)
        nrst_i <= 1;
        repeat (4) @(posedge clock_i);
        `CHK(active_range_o, RANGE_HIGH)
        print_verdict();
    end
endmodule // testbench
